// File: core/pwg_regs.svh
// Purpose: register offsets, field positions and reset values of the
//          port wake and interrupt gating block
// Assumes: included by its bare name; definitions only
// Notes:   offsets are byte addresses within one port's register page
`ifndef PWG_REGS_SVH
`define PWG_REGS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define PWG_ADDR_W 12
`define PWG_OFF_WAKE_EVENT 12'h013
`define PWG_OFF_WAKE_ENABLE 12'h017
`define PWG_OFF_IRQ_STATUS 12'h01b
`define PWG_OFF_IRQ_MASK 12'h01f

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PWG_BIT_MAGIC 2
`define PWG_BIT_LINK 1
`define PWG_BIT_ENERGY 0
`define PWG_BIT_TS_IRQ 2
`define PWG_BIT_PHY_IRQ 1
`define PWG_BIT_FILTER_IRQ 0
`define PWG_FIELD_W 3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PWG_RST_FIELD 3'h0
`define PWG_RST_BYTE 8'h00
`define PWG_RST_MAC 48'h0000_0000_0000

`endif

// File: core/pwg_pkg.sv
// Purpose: types shared by the port wake and interrupt gating block
// Assumes: pwg_regs.svh supplies the widths
// Notes:   the register bus and the event inputs travel as structs
`include "pwg_regs.svh"

package pwg_pkg;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [`PWG_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pwg_bus_t;

    typedef struct packed {
        logic magic_valid;
        logic [47:0] magic_dst;
        logic link_up;
        logic energy;
    } pwg_evt_t;

    typedef logic [`PWG_FIELD_W-1:0] pwg_field_t;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic pwg_hit(
        input logic [`PWG_ADDR_W-1:0] addr,
        input logic [`PWG_ADDR_W-1:0] off
    );
        return addr == off;
    endfunction

endpackage

// File: core/pwg_wake_latch.sv
// Purpose: sticky wake event flags for one port
// Assumes: detector pulses are synchronous to i_clock
// Notes:   a detection in the clearing cycle survives the clear
`timescale 1ns/1ps
`include "pwg_regs.svh"

module pwg_wake_latch
    import pwg_pkg::*;
#(
    parameter bit PHY_PORT = 1'b1
) (
    // clock and reset
    input logic i_clock,
    input logic i_sys_rst,
    // detections
    input pwg_evt_t i_evt,
    input logic [47:0] i_switch_mac,
    // software clear, one bit per flag
    input pwg_field_t i_clear,
    // latched flags
    output pwg_field_t o_flags
);

    pwg_field_t flags_reg;
    pwg_field_t flags_next;
    pwg_field_t set_vec;

    always_comb begin
        set_vec = `PWG_RST_FIELD;
        set_vec[`PWG_BIT_MAGIC] = i_evt.magic_valid &&
            (i_evt.magic_dst == i_switch_mac);
        set_vec[`PWG_BIT_LINK] = PHY_PORT && i_evt.link_up;
        set_vec[`PWG_BIT_ENERGY] = PHY_PORT && i_evt.energy;
        flags_next = (flags_reg & ~i_clear) | set_vec;
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            flags_reg <= `PWG_RST_FIELD;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign o_flags = flags_reg;

endmodule

// File: core/pwg_irq_gate.sv
// Purpose: port interrupt status sources for one port
// Assumes: summary inputs are levels, the filter input is a pulse
// Notes:   the filter flag only clears when its mask bit changes
`timescale 1ns/1ps
`include "pwg_regs.svh"

module pwg_irq_gate
    import pwg_pkg::*;
#(
    parameter bit PHY_PORT = 1'b1
) (
    // clock and reset
    input logic i_clock,
    input logic i_sys_rst,
    // sources
    input logic i_ts_pending,
    input logic i_phy_pending,
    input logic i_access_filter_event,
    // filter mask bit changes this cycle
    input logic i_mask_toggle,
    // status view
    output pwg_field_t o_status
);

    logic filter_reg;
    logic filter_next;

    always_comb begin
        filter_next = i_access_filter_event ||
            (filter_reg && !i_mask_toggle);
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            filter_reg <= 1'b0;
        end else begin
            filter_reg <= filter_next;
        end
    end

    always_comb begin
        o_status = `PWG_RST_FIELD;
        o_status[`PWG_BIT_TS_IRQ] = PHY_PORT && i_ts_pending;
        o_status[`PWG_BIT_PHY_IRQ] = PHY_PORT && i_phy_pending;
        o_status[`PWG_BIT_FILTER_IRQ] = filter_reg;
    end

endmodule

// File: core/pwg_port_wake_irq.sv
// Purpose: per-port wake gating and port interrupt gating, with the
//          wake event, wake enable, status and mask registers
// Assumes: register strobes are one cycle long and never overlap
// Notes:   read data stand for exactly one cycle after the read strobe
`timescale 1ns/1ps
`include "pwg_regs.svh"

// How it works
// - magic enable bit 2 lets a magic-packet detection drive the wake pin.
// - a magic packet counts only when its destination equals the switch MAC.
// - link-up enable bit 1 lets a link-up detection drive the wake pin.
// - energy enable bit 0 lets a cable-energy detection drive the wake pin.
// - link-up and energy wake sources exist only on ports with a PHY.
// - status bit 2 shows the pending timestamp summary, PHY ports only.
// - status bit 1 shows the pending PHY interrupt summary, PHY ports only.
// - status bit 0 is set by an access-filter counter-mode interrupt.
// - the access-filter status clears when software toggles its mask bit.
// - mask bits are inverted enables: 0 enables, reset value 0.
// - timestamp and PHY masks matter on PHY ports, filter mask everywhere.
// - the status register holds port interrupts only, nothing global.
// - wake detections latch as flags, cleared by a software write.
module pwg_port_wake_irq
    import pwg_pkg::*;
#(
    parameter bit PHY_PORT = 1'b1
) (
    // clock and reset
    input logic i_clock,
    input logic i_sys_rst,
    // register port
    input pwg_bus_t i_bus,
    output logic [7:0] o_rd_data,
    // wake detections and switch address
    input pwg_evt_t i_evt,
    input logic [47:0] i_switch_mac,
    // interrupt sources
    input logic i_ts_pending,
    input logic i_phy_pending,
    input logic i_access_filter_event,
    // outputs
    output logic o_power_mgmt_event_out,
    output logic o_port_irq
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    logic hit_event;
    logic hit_enable;
    logic hit_status;
    logic hit_mask;

    always_comb begin
        hit_event = pwg_hit(i_bus.addr, `PWG_OFF_WAKE_EVENT);
        hit_enable = pwg_hit(i_bus.addr, `PWG_OFF_WAKE_ENABLE);
        hit_status = pwg_hit(i_bus.addr, `PWG_OFF_IRQ_STATUS);
        hit_mask = pwg_hit(i_bus.addr, `PWG_OFF_IRQ_MASK);
    end

    // ------------------------------------------------------------------
    // wake event flags
    // ------------------------------------------------------------------
    pwg_field_t wake_flags;
    pwg_field_t wake_clear;

    always_comb begin
        wake_clear = `PWG_RST_FIELD;
        // write one to clear, read clears too
        if (i_bus.wr && hit_event) begin
            wake_clear = i_bus.wdata[`PWG_FIELD_W-1:0];
        end else if (i_bus.rd && hit_event) begin
            wake_clear = ~`PWG_RST_FIELD;
        end
    end

    pwg_wake_latch #(
        .PHY_PORT(PHY_PORT)
    ) u_wake_latch (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_evt(i_evt),
        .i_switch_mac(i_switch_mac),
        .i_clear(wake_clear),
        .o_flags(wake_flags)
    );

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    pwg_field_t wake_en_reg;
    pwg_field_t wake_en_next;
    pwg_field_t mask_reg;
    pwg_field_t mask_next;
    logic mask_toggle;

    always_comb begin
        wake_en_next = wake_en_reg;
        mask_next = mask_reg;
        if (i_bus.wr && hit_enable) begin
            wake_en_next = i_bus.wdata[`PWG_FIELD_W-1:0];
            if (!PHY_PORT) begin
                wake_en_next[`PWG_BIT_LINK] = 1'b0;
                wake_en_next[`PWG_BIT_ENERGY] = 1'b0;
            end
        end else if (i_bus.wr && hit_mask) begin
            mask_next = i_bus.wdata[`PWG_FIELD_W-1:0];
        end
        mask_toggle = mask_next[`PWG_BIT_FILTER_IRQ] !=
            mask_reg[`PWG_BIT_FILTER_IRQ];
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            wake_en_reg <= `PWG_RST_FIELD;
            mask_reg <= `PWG_RST_FIELD;
        end else begin
            wake_en_reg <= wake_en_next;
            mask_reg <= mask_next;
        end
    end

    // ------------------------------------------------------------------
    // interrupt sources
    // ------------------------------------------------------------------
    pwg_field_t irq_status;

    pwg_irq_gate #(
        .PHY_PORT(PHY_PORT)
    ) u_irq_gate (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_ts_pending(i_ts_pending),
        .i_phy_pending(i_phy_pending),
        .i_access_filter_event(i_access_filter_event),
        .i_mask_toggle(mask_toggle),
        .o_status(irq_status)
    );

    // ------------------------------------------------------------------
    // outputs and read data
    // ------------------------------------------------------------------
    logic wake_out_reg;
    logic wake_out_next;
    logic irq_reg;
    logic irq_next;
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;

    always_comb begin
        wake_out_next = |(wake_flags & wake_en_reg);
        // unmasked status drives irq, mask is inverted
        irq_next = |(irq_status & ~mask_reg);
        rd_data_next = `PWG_RST_BYTE;
        if (i_bus.rd && hit_event) begin
            rd_data_next[`PWG_FIELD_W-1:0] = wake_flags;
        end else if (i_bus.rd && hit_enable) begin
            rd_data_next[`PWG_FIELD_W-1:0] = wake_en_reg;
        end else if (i_bus.rd && hit_status) begin
            rd_data_next[`PWG_FIELD_W-1:0] = irq_status;
        end else if (i_bus.rd && hit_mask) begin
            rd_data_next[`PWG_FIELD_W-1:0] = mask_reg;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            wake_out_reg <= 1'b0;
            irq_reg <= 1'b0;
            rd_data_reg <= `PWG_RST_BYTE;
        end else begin
            wake_out_reg <= wake_out_next;
            irq_reg <= irq_next;
            rd_data_reg <= rd_data_next;
        end
    end

    assign o_power_mgmt_event_out = wake_out_reg;
    assign o_port_irq = irq_reg;
    assign o_rd_data = rd_data_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    magic_wake_a: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        (wake_flags[`PWG_BIT_MAGIC] && wake_en_reg[`PWG_BIT_MAGIC])
        |=> o_power_mgmt_event_out
    ) else $error("magic wake not signalled");

    magic_match_a: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        (i_evt.magic_valid && i_evt.magic_dst != i_switch_mac &&
         !wake_flags[`PWG_BIT_MAGIC])
        |=> !wake_flags[`PWG_BIT_MAGIC]
    ) else $error("magic flag set by foreign address");

    link_wake_a: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        (wake_flags[`PWG_BIT_LINK] && wake_en_reg[`PWG_BIT_LINK])
        |=> o_power_mgmt_event_out
    ) else $error("link-up wake not signalled");

    energy_wake_a: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        (wake_flags[`PWG_BIT_ENERGY] && wake_en_reg[`PWG_BIT_ENERGY])
        |=> o_power_mgmt_event_out
    ) else $error("energy wake not signalled");

    wake_gated_a: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        ((wake_flags & wake_en_reg) == `PWG_RST_FIELD)
        |=> !o_power_mgmt_event_out
    ) else $error("wake asserted without enabled flag");

    mac_only_a: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        !PHY_PORT |-> (wake_flags[1:0] == 2'b00 &&
            wake_en_reg[1:0] == 2'b00)
    ) else $error("phy wake source on mac port");

    ts_status_a: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        (i_bus.rd && hit_status)
        |=> o_rd_data[`PWG_BIT_TS_IRQ] == $past(PHY_PORT && i_ts_pending)
    ) else $error("timestamp status misread");

    phy_status_a: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        (i_bus.rd && hit_status)
        |=> o_rd_data[`PWG_BIT_PHY_IRQ] ==
            $past(PHY_PORT && i_phy_pending)
    ) else $error("phy status misread");

    filter_set_a: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        i_access_filter_event |=> irq_status[`PWG_BIT_FILTER_IRQ]
    ) else $error("filter event not latched");

    filter_clear_a: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        (mask_toggle && !i_access_filter_event)
        |=> !irq_status[`PWG_BIT_FILTER_IRQ]
    ) else $error("filter flag survived mask toggle");

    irq_gate_a: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        ((irq_status & ~mask_reg) != `PWG_RST_FIELD) |=> o_port_irq
    ) else $error("unmasked status gave no irq");

    irq_quiet_a: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        ((irq_status & ~mask_reg) == `PWG_RST_FIELD) |=> !o_port_irq
    ) else $error("irq without unmasked status");

    reserved_zero_a: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        i_bus.rd |=> o_rd_data[7:3] == 5'h00
    ) else $error("reserved bits not zero");

    event_clear_a: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        (i_bus.wr && hit_event && i_bus.wdata[`PWG_BIT_MAGIC] &&
         !i_evt.magic_valid)
        |=> !wake_flags[`PWG_BIT_MAGIC]
    ) else $error("magic flag not cleared by write");

endmodule

// File: verification/pwg_port_wake_irq_tb.sv
// Purpose: self-checking bench of the port wake and interrupt gating block
// Assumes: one clock; reads return data the cycle after the strobe
// Notes:   a phy port and a mac-only port share every input
`timescale 1ns/1ps
`include "pwg_regs.svh"

module pwg_port_wake_irq_tb
    import pwg_pkg::*;
;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    pwg_bus_t bus = '0;
    pwg_evt_t evt = '0;
    logic [47:0] mac_addr;
    logic ts_pend = 1'b0;
    logic phy_pend = 1'b0;
    logic afe = 1'b0;
    logic [7:0] rd_phy;
    logic [7:0] rd_mac;
    logic wake_phy;
    logic wake_mac;
    logic irq_phy;
    logic irq_mac;
    logic [15:0] notes[$];
    logic [15:0] note;
    logic rd_seen = 1'b0;
    logic [31:0] seed = 32'h0000_b672;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;

    always #10 i_clock = ~i_clock;

    // ------------------------------------------------------------------
    // devices under test
    // ------------------------------------------------------------------
    pwg_port_wake_irq #(.PHY_PORT(1'b1)) pwg_port_wake_irq_i (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_bus(bus),
        .o_rd_data(rd_phy), .i_evt(evt), .i_switch_mac(mac_addr),
        .i_ts_pending(ts_pend), .i_phy_pending(phy_pend),
        .i_access_filter_event(afe), .o_power_mgmt_event_out(wake_phy),
        .o_port_irq(irq_phy)
    );

    // mac-only port sees the same traffic, so one note covers both reads
    pwg_port_wake_irq #(.PHY_PORT(1'b0)) pwg_port_wake_irq_mac_i (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_bus(bus),
        .o_rd_data(rd_mac), .i_evt(evt), .i_switch_mac(mac_addr),
        .i_ts_pending(ts_pend), .i_phy_pending(phy_pend),
        .i_access_filter_event(afe), .o_power_mgmt_event_out(wake_mac),
        .o_port_irq(irq_mac)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        if (miscompares == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    // pin order: phy wake, phy irq, mac wake, mac irq
    task automatic pins(input logic [3:0] e);
        check("pins", {4'h0, wake_phy, irq_phy, wake_mac, irq_mac},
              {4'h0, e});
    endtask

    task automatic wr(input logic [`PWG_ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge i_clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clock);
        bus <= '0;
    endtask

    task automatic rd(input logic [`PWG_ADDR_W-1:0] a, input logic [7:0] e,
                      input logic [7:0] em);
        notes.push_back({e, em});
        @(posedge i_clock);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clock);
        bus <= '0;
    endtask

    // source 0 energy, 1 link, 2 magic, 3 filter counter
    task automatic pulse(input int s, input logic [47:0] dst);
        pwg_evt_t e;
        e = '0;
        e.energy = (s == 0);
        e.link_up = (s == 1);
        e.magic_valid = (s == 2);
        e.magic_dst = dst;
        @(posedge i_clock);
        evt <= e;
        afe <= (s == 3);
        @(posedge i_clock);
        evt <= '0;
        afe <= 1'b0;
    endtask

    // ------------------------------------------------------------------
    // read monitor and watchdog
    // ------------------------------------------------------------------
    always @(posedge i_clock) begin
        if (rd_seen) begin
            note = notes.pop_front();
            check("rd_phy", rd_phy, note[15:8]);
            check("rd_mac", rd_mac, note[7:0]);
        end
        rd_seen <= bus.rd;
    end

    // ceiling is some twenty times the length of the sequence
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            miscompares++;
            test_done();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [7:0] m;
        logic [7:0] b;
        mac_addr = 48'({rnd(), rnd()});
        repeat (12) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        tick(1);
        pins(4'h0);
        rd(`PWG_OFF_WAKE_EVENT, 8'h00, 8'h00);
        rd(`PWG_OFF_WAKE_ENABLE, 8'h00, 8'h00);
        rd(`PWG_OFF_IRQ_STATUS, 8'h00, 8'h00);
        rd(`PWG_OFF_IRQ_MASK, 8'h00, 8'h00);
        wr(`PWG_OFF_WAKE_ENABLE, 8'hff);
        rd(`PWG_OFF_WAKE_ENABLE, 8'h07, 8'h04);
        wr(`PWG_OFF_IRQ_STATUS, 8'hff);
        wr(12'h020, 8'hff);
        rd(`PWG_OFF_IRQ_STATUS, 8'h00, 8'h00);
        rd(12'h020, 8'h00, 8'h00);
        // each wake source with its enable off, then on
        for (int s = 0; s < 3; s++) begin
            b = 8'h01 << s;
            wr(`PWG_OFF_WAKE_ENABLE, ~b & 8'h07);
            pulse(s, mac_addr);
            tick(3);
            pins(4'h0);
            rd(`PWG_OFF_WAKE_EVENT, b, (s == 2) ? b : 8'h00);
            wr(`PWG_OFF_WAKE_ENABLE, b);
            pulse(s, mac_addr);
            tick(3);
            pins((s == 2) ? 4'b1010 : 4'b1000);
            wr(`PWG_OFF_WAKE_EVENT, b);
            tick(2);
            pins(4'h0);
            rd(`PWG_OFF_WAKE_EVENT, 8'h00, 8'h00);
        end
        // magic packet to a foreign destination
        pulse(2, mac_addr ^ (48'h0000_0000_0001 << (rnd() % 48)));
        tick(3);
        pins(4'h0);
        rd(`PWG_OFF_WAKE_EVENT, 8'h00, 8'h00);
        wr(`PWG_OFF_WAKE_ENABLE, 8'h00);
        // summary sources are levels, masked with inverted sense
        for (int s = 1; s < 3; s++) begin
            b = 8'h01 << s;
            @(posedge i_clock);
            ts_pend <= (s == 2);
            phy_pend <= (s == 1);
            tick(2);
            pins(4'b0100);
            rd(`PWG_OFF_IRQ_STATUS, b, 8'h00);
            wr(`PWG_OFF_IRQ_MASK, b);
            tick(2);
            pins(4'h0);
            rd(`PWG_OFF_IRQ_STATUS, b, 8'h00);
            wr(`PWG_OFF_IRQ_MASK, 8'h00);
            @(posedge i_clock);
            ts_pend <= 1'b0;
            phy_pend <= 1'b0;
            tick(2);
            pins(4'h0);
        end
        // filter flag is sticky until its mask bit toggles
        pulse(3, mac_addr);
        tick(2);
        pins(4'b0101);
        rd(`PWG_OFF_IRQ_STATUS, 8'h01, 8'h01);
        rd(`PWG_OFF_IRQ_STATUS, 8'h01, 8'h01);
        wr(`PWG_OFF_IRQ_MASK, 8'h01);
        tick(2);
        pins(4'h0);
        rd(`PWG_OFF_IRQ_STATUS, 8'h00, 8'h00);
        wr(`PWG_OFF_IRQ_MASK, 8'h00);
        wr(`PWG_OFF_IRQ_MASK, 8'h01);
        pulse(3, mac_addr);
        tick(2);
        pins(4'h0);
        rd(`PWG_OFF_IRQ_STATUS, 8'h01, 8'h01);
        wr(`PWG_OFF_IRQ_MASK, 8'h00);
        tick(2);
        pins(4'h0);
        rd(`PWG_OFF_IRQ_STATUS, 8'h00, 8'h00);
        // random mask values keep only the three live bits
        repeat (4) begin
            m = 8'(rnd());
            wr(`PWG_OFF_IRQ_MASK, m);
            rd(`PWG_OFF_IRQ_MASK, m & 8'h07, m & 8'h07);
        end
        tick(3);
        test_done();
    end
endmodule
